/* File: logic/urm_pkg.sv */
package urm_pkg;

    // ------------------------------------------------------------------
    // register offsets on the three low address lines
    // ------------------------------------------------------------------
    localparam logic [2:0] ADDR_HOLD = 3'h0; // holding / divisor low
    localparam logic [2:0] ADDR_IER = 3'h1; // enables / divisor high
    localparam logic [2:0] ADDR_ISR = 3'h2; // status, queue, fraction, efr
    localparam logic [2:0] ADDR_LCR = 3'h3;
    localparam logic [2:0] ADDR_MCR = 3'h4; // also first resume char
    localparam logic [2:0] ADDR_LSR = 3'h5; // also second resume char
    localparam logic [2:0] ADDR_MSR = 3'h6; // also first pause char
    localparam logic [2:0] ADDR_SPR = 3'h7; // also second pause char

    // ------------------------------------------------------------------
    // key values, bit positions and masks
    // ------------------------------------------------------------------
    localparam logic [7:0] LCR_ENH_KEY = 8'hBF; // opens enhanced set
    localparam int LCR_DLAB_BIT = 7; // divisor enable
    localparam int EFR_ENH_BIT = 4; // enhanced enable
    localparam int FCR_EN_BIT = 0;
    localparam int FCR_RXCLR_BIT = 1;
    localparam int FCR_TXCLR_BIT = 2;
    localparam logic [7:0] IER_ENH_MASK = 8'hF0;
    localparam logic [7:0] FCR_ENH_MASK = 8'h30;
    localparam logic [7:0] MCR_ENH_MASK = 8'hE0;
    localparam logic [7:0] ISR_ENH_MASK = 8'h30;
    localparam logic [7:0] MCR_RSVD_MASK = 8'h04;
    localparam logic [7:0] DLD_RSVD_MASK = 8'hC0;
    localparam logic [7:0] FCR_PULSE_MASK = 8'h06; // self-clearing
    localparam logic [7:0] REG_RESET = 8'h00; // every register
    localparam logic [3:0] NIB_RESET = 4'h0;

    // ------------------------------------------------------------------
    // decoded register selection
    // ------------------------------------------------------------------
    typedef enum logic [4:0] {
        SEL_NONE = 5'b00000,
        SEL_HOLD = 5'b00001,
        SEL_DLL = 5'b00010,
        SEL_DLM = 5'b00011,
        SEL_DLD = 5'b00100,
        SEL_IER = 5'b00101,
        SEL_ISR = 5'b00110,
        SEL_LCR = 5'b00111,
        SEL_MCR = 5'b01000,
        SEL_LSR = 5'b01001,
        SEL_MSR = 5'b01010,
        SEL_SPR = 5'b01011,
        SEL_EFR = 5'b01100,
        SEL_XON1 = 5'b01101,
        SEL_XON2 = 5'b01110,
        SEL_XOFF1 = 5'b01111,
        SEL_XOFF2 = 5'b10000
    } urm_sel_e;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic cs; // channel select
        logic wr; // write strobe
        logic rd; // read strobe
        logic [2:0] addr;
        logic [7:0] wdata;
    } urm_bus_s;

    typedef struct packed {
        logic [7:0] rx_byte; // head of receive path
        logic [3:0] int_source; // interrupt source code
        logic xoff_int;
        logic flow_int; // rts/cts handshake interrupt
        logic [7:0] line; // line status bits
        logic [3:0] modem; // cd, ri, dsr, cts (bit 3..0)
    } urm_stat_s;

    typedef struct packed {
        logic [7:0] dll;
        logic [7:0] baud_divisor_high;
        logic [7:0] baud_divisor_fraction; // effective, gated
        logic [7:0] interrupt_enables; // effective, gated
        logic [7:0] queue_control; // stored bits, gated
        logic [7:0] line_format_control;
        logic [7:0] modem_line_control; // effective, gated
        logic [7:0] enhanced_function;
        logic [7:0] xon1;
        logic [7:0] xon2;
        logic [7:0] xoff1;
        logic [7:0] xoff2;
    } urm_cfg_s;

endpackage : urm_pkg

/* File: logic/urm_channel_regs.sv */
module urm_channel_regs
    import urm_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // host register bus
    input wire urm_bus_s bus,
    output logic [7:0] rdata,
    // serial engine side
    input wire urm_stat_s stat,
    output urm_cfg_s cfg,
    output logic [7:0] tx_byte,
    output logic tx_load,
    output logic rx_pop,
    output logic rx_fifo_clr,
    output logic tx_fifo_clr
);

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    function automatic urm_sel_e urm_decode(input logic [2:0] a,
                                            input logic [7:0] lcr_v,
                                            input logic enh_v);
        logic key;
        logic dl;
        key = (lcr_v == LCR_ENH_KEY);
        dl = lcr_v[LCR_DLAB_BIT];
        urm_decode = SEL_NONE;
        if (a == ADDR_LCR) begin
            urm_decode = SEL_LCR;
        end else if (key && a == ADDR_ISR) begin
            urm_decode = SEL_EFR;
        end else if (key && a == ADDR_MCR) begin
            urm_decode = SEL_XON1;
        end else if (key && a == ADDR_LSR) begin
            urm_decode = SEL_XON2;
        end else if (key && a == ADDR_MSR) begin
            urm_decode = SEL_XOFF1;
        end else if (key && a == ADDR_SPR) begin
            urm_decode = SEL_XOFF2;
        end else if (key) begin
            urm_decode = SEL_NONE; // key hides addresses 0 and 1
        end else if (dl && a == ADDR_HOLD) begin
            urm_decode = SEL_DLL;
        end else if (dl && a == ADDR_IER) begin
            urm_decode = SEL_DLM;
        end else if (dl && a == ADDR_ISR) begin
            urm_decode = enh_v ? SEL_DLD : SEL_NONE;
        end else if (a == ADDR_HOLD) begin
            urm_decode = SEL_HOLD;
        end else if (a == ADDR_IER) begin
            urm_decode = SEL_IER;
        end else if (a == ADDR_ISR) begin
            urm_decode = SEL_ISR;
        end else if (a == ADDR_MCR) begin
            urm_decode = SEL_MCR;
        end else if (a == ADDR_LSR) begin
            urm_decode = SEL_LSR;
        end else if (a == ADDR_MSR) begin
            urm_decode = SEL_MSR;
        end else begin
            urm_decode = SEL_SPR;
        end
    endfunction : urm_decode

    // ------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------
    logic [7:0] dll; // divisor low
    logic [7:0] baud_divisor_high; // divisor high
    logic [7:0] baud_divisor_fraction; // divisor fraction, raw
    logic [7:0] interrupt_enables; // interrupt enables, raw
    logic [7:0] queue_control; // queue control, raw
    logic [7:0] line_format_control; // line format control
    logic [7:0] modem_line_control; // modem line control, raw
    logic [7:0] enhanced_function; // enhanced function
    logic [7:0] xon1;
    logic [7:0] xon2;
    logic [7:0] xoff1;
    logic [7:0] xoff2;
    logic [7:0] scratch_byte; // scratch byte
    logic [3:0] modem_prev; // last modem input sample
    logic [3:0] modem_delta; // sticky change flags
    logic primed; // first sample after reset taken

    // ------------------------------------------------------------------
    // decode and gating wires
    // ------------------------------------------------------------------
    wire logic enh = enhanced_function[EFR_ENH_BIT];
    wire logic [7:0] enh_keep = enh ? 8'hFF : 8'h00;
    wire urm_sel_e sel = urm_decode(bus.addr, line_format_control, enh);
    wire logic wr_en = bus.cs && bus.wr;
    wire logic rd_en = bus.cs && bus.rd;
    // stored values: gated bits are dropped on the way in
    wire logic [7:0] ier_in = bus.wdata & (~IER_ENH_MASK | enh_keep);
    wire logic [7:0] fcr_in = bus.wdata & ~FCR_PULSE_MASK
                              & (~FCR_ENH_MASK | enh_keep);
    wire logic [7:0] mcr_in = bus.wdata & ~MCR_RSVD_MASK
                              & (~MCR_ENH_MASK | enh_keep);
    wire logic [7:0] dld_in = bus.wdata & ~DLD_RSVD_MASK;
    // effective values: bits set earlier vanish once enhanced is off
    wire logic [7:0] ier_eff = interrupt_enables & (~IER_ENH_MASK | enh_keep);
    wire logic [7:0] fcr_eff = queue_control & (~FCR_ENH_MASK | enh_keep);
    wire logic [7:0] mcr_eff = modem_line_control & (~MCR_ENH_MASK | enh_keep);
    wire logic [7:0] isr_val = {{2{queue_control[FCR_EN_BIT]}},
                                stat.flow_int, stat.xoff_int,
                                stat.int_source}
                               & (~ISR_ENH_MASK | enh_keep);
    wire logic [7:0] msr_val = {stat.modem, modem_delta};

    // ------------------------------------------------------------------
    // read selection
    // ------------------------------------------------------------------
    logic [7:0] rd_mux;
    always_comb begin
        // unmapped or hidden slots read zero
        case (sel)
            SEL_HOLD: rd_mux = stat.rx_byte;
            SEL_DLL: rd_mux = dll;
            SEL_DLM: rd_mux = baud_divisor_high;
            SEL_DLD: rd_mux = baud_divisor_fraction;
            SEL_IER: rd_mux = ier_eff;
            SEL_ISR: rd_mux = isr_val;
            SEL_LCR: rd_mux = line_format_control;
            SEL_MCR: rd_mux = mcr_eff;
            SEL_LSR: rd_mux = stat.line;
            SEL_MSR: rd_mux = msr_val;
            SEL_SPR: rd_mux = scratch_byte;
            SEL_EFR: rd_mux = enhanced_function;
            SEL_XON1: rd_mux = xon1;
            SEL_XON2: rd_mux = xon2;
            SEL_XOFF1: rd_mux = xoff1;
            SEL_XOFF2: rd_mux = xoff2;
            default: rd_mux = REG_RESET;
        endcase
    end

    // ------------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------------
    // writes to read-only slots (line, modem) are dropped; status slot writes go to queue control
    always_ff @(posedge clk) begin
        if (srst) begin
            {dll, baud_divisor_high, baud_divisor_fraction, interrupt_enables, queue_control, line_format_control} <= {6{REG_RESET}};
            {modem_line_control, enhanced_function, xon1, xon2, xoff1, xoff2, scratch_byte} <= {7{REG_RESET}};
        end else if (wr_en) begin
            case (sel)
                SEL_DLL: dll <= bus.wdata;
                SEL_DLM: baud_divisor_high <= bus.wdata;
                SEL_DLD: baud_divisor_fraction <= dld_in;
                SEL_IER: interrupt_enables <= ier_in;
                SEL_ISR: queue_control <= fcr_in;
                SEL_LCR: line_format_control <= bus.wdata;
                SEL_MCR: modem_line_control <= mcr_in;
                SEL_SPR: scratch_byte <= bus.wdata;
                SEL_EFR: enhanced_function <= bus.wdata;
                SEL_XON1: xon1 <= bus.wdata;
                SEL_XON2: xon2 <= bus.wdata;
                SEL_XOFF1: xoff1 <= bus.wdata;
                SEL_XOFF2: xoff2 <= bus.wdata;
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // strobes towards the serial engine and read data
    // ------------------------------------------------------------------
    // one-cycle pulses; fifo clears never stick, as the host expects
    always_ff @(posedge clk) begin
        if (srst) begin
            tx_load <= 1'b0;
            rx_pop <= 1'b0;
            rx_fifo_clr <= 1'b0;
            tx_fifo_clr <= 1'b0;
            tx_byte <= REG_RESET;
            rdata <= REG_RESET;
        end else begin
            tx_load <= wr_en && sel == SEL_HOLD;
            rx_pop <= rd_en && sel == SEL_HOLD;
            rx_fifo_clr <= wr_en && sel == SEL_ISR
                           && bus.wdata[FCR_RXCLR_BIT];
            tx_fifo_clr <= wr_en && sel == SEL_ISR
                           && bus.wdata[FCR_TXCLR_BIT];
            if (wr_en && sel == SEL_HOLD) begin
                tx_byte <= bus.wdata;
            end
            if (rd_en) begin
                rdata <= rd_mux; // held until the next read
            end
        end
    end

    // ------------------------------------------------------------------
    // modem change flags
    // ------------------------------------------------------------------
    // a change in the cycle of an msr read is kept: set wins over clear
    wire logic msr_clr = rd_en && sel == SEL_MSR;
    wire logic [3:0] msr_keep = msr_clr ? NIB_RESET : modem_delta;
    wire logic [3:0] msr_set = primed ? (modem_prev ^ stat.modem) : NIB_RESET;
    always_ff @(posedge clk) begin
        if (srst) begin
            modem_prev <= NIB_RESET;
            modem_delta <= NIB_RESET;
            primed <= 1'b0;
        end else begin
            modem_prev <= stat.modem;
            primed <= 1'b1; // first sample only sets the baseline
            modem_delta <= msr_keep | msr_set;
        end
    end

    // ------------------------------------------------------------------
    // outputs to the serial engine
    // ------------------------------------------------------------------
    assign cfg = '{dll: dll, baud_divisor_high: baud_divisor_high, baud_divisor_fraction: baud_divisor_fraction & enh_keep,
                   interrupt_enables: ier_eff, queue_control: fcr_eff, line_format_control: line_format_control,
                   modem_line_control: mcr_eff, enhanced_function: enhanced_function, xon1: xon1, xon2: xon2,
                   xoff1: xoff1, xoff2: xoff2};

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    wire logic key_now = (line_format_control == LCR_ENH_KEY);
    wire logic dl_now = line_format_control[LCR_DLAB_BIT];

    property p_idle_bus;
        !bus.cs |=> $stable(cfg) && !tx_load && !rx_pop;
    endproperty
    a_idle_bus: assert property (p_idle_bus)
        else $error("register state moved without channel select");

    property p_hold_read;
        rd_en && bus.addr == ADDR_HOLD && !dl_now
        |=> rx_pop && rdata == $past(stat.rx_byte);
    endproperty
    a_hold_read: assert property (p_hold_read)
        else $error("receive byte read did not return or pop");

    property p_hold_write;
        wr_en && bus.addr == ADDR_HOLD && !dl_now
        |=> tx_load && tx_byte == $past(bus.wdata);
    endproperty
    a_hold_write: assert property (p_hold_write)
        else $error("transmit byte write not passed on");

    property p_div_low;
        wr_en && bus.addr == ADDR_HOLD && dl_now && !key_now
        |=> cfg.dll == $past(bus.wdata) && !tx_load;
    endproperty
    a_div_low: assert property (p_div_low)
        else $error("divisor low write went astray");

    property p_frac_gate;
        wr_en && bus.addr == ADDR_ISR && dl_now && !key_now && !enh
        |=> $stable(baud_divisor_fraction) && !rx_fifo_clr;
    endproperty
    a_frac_gate: assert property (p_frac_gate)
        else $error("fraction written while enhanced off");

    property p_efr_write;
        wr_en && bus.addr == ADDR_ISR && key_now
        |=> enhanced_function == $past(bus.wdata) && !rx_fifo_clr && !tx_fifo_clr;
    endproperty
    a_efr_write: assert property (p_efr_write)
        else $error("enhanced function write went astray");

    property p_pause_write;
        wr_en && bus.addr == ADDR_SPR && key_now
        |=> cfg.xoff2 == $past(bus.wdata) && $stable(scratch_byte);
    endproperty
    a_pause_write: assert property (p_pause_write)
        else $error("second pause character write went astray");

    property p_gated_zero;
        !enh |-> (cfg.interrupt_enables & IER_ENH_MASK) == REG_RESET
                 && (cfg.modem_line_control & MCR_ENH_MASK) == REG_RESET;
    endproperty
    a_gated_zero: assert property (p_gated_zero)
        else $error("enhanced bits active while enhanced off");

    property p_isr_fifo;
        rd_en && bus.addr == ADDR_ISR && !dl_now
        |=> rdata[7:6] == {2{$past(queue_control[FCR_EN_BIT])}};
    endproperty
    a_isr_fifo: assert property (p_isr_fifo)
        else $error("status read lost fifo enable bits");

    property p_fifo_clear;
        wr_en && bus.addr == ADDR_ISR && !dl_now
        |=> rx_fifo_clr == $past(bus.wdata[FCR_RXCLR_BIT])
            && queue_control[FCR_RXCLR_BIT] == 1'b0;
    endproperty
    a_fifo_clear: assert property (p_fifo_clear)
        else $error("receive fifo clear pulse wrong");

    // transmit clear is a pulse too and must never be stored
    property p_tx_clear;
        wr_en && bus.addr == ADDR_ISR && !dl_now
        |=> tx_fifo_clr == $past(bus.wdata[FCR_TXCLR_BIT])
            && queue_control[FCR_TXCLR_BIT] == 1'b0;
    endproperty
    a_tx_clear: assert property (p_tx_clear)
        else $error("transmit fifo clear pulse wrong");

    property p_msr_read;
        rd_en && sel == SEL_MSR |=> rdata[7:4] == $past(stat.modem);
    endproperty
    a_msr_read: assert property (p_msr_read)
        else $error("modem state read wrong");

    property p_scratch;
        (wr_en && !rd_en && bus.addr == ADDR_SPR && !key_now)
        ##1 (rd_en && !wr_en && sel == SEL_SPR)
        |=> rdata == $past(bus.wdata, 2);
    endproperty
    a_scratch: assert property (p_scratch)
        else $error("scratch byte did not read back");

    c_key_open: cover property (wr_en && sel == SEL_LCR
                                && bus.wdata == LCR_ENH_KEY);
    c_frac_write: cover property (wr_en && sel == SEL_DLD);
    c_msr_change: cover property (|modem_delta ##1 msr_clr);
    c_tx_then_rx: cover property (tx_load ##[1:4] rx_pop);

endmodule : urm_channel_regs

/* File: verification/urm_host_model.sv */
module urm_host_model
    import urm_pkg::*;
(
    // clock
    input wire logic clk,
    // register bus toward the channel
    output urm_bus_s bus,
    input wire logic [7:0] rdata
);
    timeunit 1ns;
    timeprecision 1ps;

    // --------------------------------------------
    // bus cycles
    // --------------------------------------------
    // idle until the first request
    initial bus = '0;

    // one cycle: request held up to and through the taking edge
    task automatic cyc(input logic c, w, r, input logic [2:0] a,
                       input logic [7:0] d, output logic [7:0] q);
        @(posedge clk);
        bus <= '{cs: c, wr: w, rd: r, addr: a, wdata: d};
        @(posedge clk);
        // released lines show the inverse, never a stale copy
        bus <= '{cs: 1'b0, wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
        // read data lands at the taking edge
        #1 q = rdata;
    endtask : cyc

endmodule : urm_host_model

/* File: verification/tb_uart_channel_register_map.sv */
module tb_uart_channel_register_map
    import urm_pkg::*;
    ;
    timeunit 1ns;
    timeprecision 1ps;

    // --------------------------------------------
    // clock, reset, design and host
    // --------------------------------------------
    logic clk = 1'b0;
    logic srst = 1'b1;
    urm_bus_s bus;
    logic [7:0] rdata;
    urm_stat_s stat = '0; // engine status, bench driven
    urm_cfg_s cfg;
    logic [7:0] tx_byte;
    logic tx_load, rx_pop, rx_fifo_clr, tx_fifo_clr;
    int mismatches = 0;
    int num_checks = 0;
    int cycles = 0;
    logic [31:0] seed = 32'h0000_0029;
    logic [7:0] q, v, x, d;
    logic [7:0] xs [4:7]; // flow characters written
    logic [3:0] old_m; // last modem state seen

    initial begin
        forever #10 clk = ~clk;
    end

    urm_channel_regs i_urm_channel_regs (
        .clk(clk), .srst(srst), .bus(bus), .rdata(rdata), .stat(stat),
        .cfg(cfg), .tx_byte(tx_byte), .tx_load(tx_load), .rx_pop(rx_pop),
        .rx_fifo_clr(rx_fifo_clr), .tx_fifo_clr(tx_fifo_clr)
    );
    urm_host_model i_urm_host_model (.clk(clk), .bus(bus), .rdata(rdata));

    // --------------------------------------------
    // expectations and helpers
    // --------------------------------------------
    // xorshift, fixed start so runs repeat
    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction : rnd

    // enhanced bits vanish while enhanced mode is off
    function automatic logic [7:0] gate(input logic [7:0] r, m,
                                        input logic en);
        return en ? r : (r & ~m);
    endfunction : gate

    // status byte from the engine inputs
    function automatic logic [7:0] f_isr(input logic [7:0] r,
                                         input logic fen, en);
        return {{2{fen}}, r[5:4] & {2{en}}, r[3:0]};
    endfunction : f_isr

    task automatic chk8(input string n, input logic [7:0] e, g);
        num_checks++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk8

    task automatic chk1(input string n, input logic e, g);
        num_checks++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value %s expected %b seen %b", n, e, g);
        end
    endtask : chk1

    task automatic wr(input logic [2:0] a, input logic [7:0] dd);
        i_urm_host_model.cyc(1'b1, 1'b1, 1'b0, a, dd, q);
    endtask : wr

    // read and compare in one go
    task automatic rdc(input logic [2:0] a, input logic [7:0] e,
                       input string n);
        i_urm_host_model.cyc(1'b1, 1'b0, 1'b1, a, 8'h00, q);
        chk8(n, e, q);
    endtask : rdc

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_of_test

    // hang guard, far above the few hundred cycles needed
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            mismatches++;
            end_of_test();
        end
    end

    // --------------------------------------------
    // main sequence
    // --------------------------------------------
    initial begin
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        rdc(ADDR_LCR, REG_RESET, "lcr_reset");
        rdc(ADDR_IER, REG_RESET, "ier_reset");
        // format and scratch, with a deselected write in between
        for (int i = 0; i < 8; i++) begin
            v = rnd() & 8'h7F;
            wr(ADDR_LCR, v);
            rdc(ADDR_LCR, v, "lcr");
            chk8("cfg_lcr", v, cfg.line_format_control);
            v = rnd();
            wr(ADDR_SPR, v);
            i_urm_host_model.cyc(1'b0, 1'b1, 1'b0, ADDR_SPR, ~v, q);
            rdc(ADDR_SPR, v, "scratch");
        end
        $display("test format and scratch done");
        // holding bytes both ways
        wr(ADDR_LCR, 8'h00);
        for (int i = 0; i < 4; i++) begin
            v = rnd();
            wr(ADDR_HOLD, v);
            chk8("tx_byte", v, tx_byte);
            chk1("tx_load", 1'b1, tx_load);
            v = rnd();
            @(posedge clk) stat.rx_byte <= v;
            #1 chk1("tx_load_end", 1'b0, tx_load);
            rdc(ADDR_HOLD, v, "rx_byte");
            chk1("rx_pop", 1'b1, rx_pop);
        end
        $display("test holding done");
        // divisor latches; fraction stays shut while enhanced is off
        wr(ADDR_LCR, 8'h80);
        v = rnd();
        wr(ADDR_HOLD, v);
        chk1("tx_load_div", 1'b0, tx_load);
        wr(ADDR_IER, ~v);
        rdc(ADDR_HOLD, v, "dll");
        chk1("rx_pop_div", 1'b0, rx_pop);
        rdc(ADDR_IER, ~v, "dlm");
        chk8("cfg_dlm", ~v, cfg.baud_divisor_high);
        wr(ADDR_ISR, 8'hFF);
        rdc(ADDR_ISR, 8'h00, "dld_shut");
        $display("test divisor done");
        // enhanced set behind the key value
        wr(ADDR_LCR, LCR_ENH_KEY);
        v = rnd() | 8'h10;
        wr(ADDR_ISR, v);
        rdc(ADDR_ISR, v, "efr");
        chk8("cfg_efr", v, cfg.enhanced_function);
        rdc(ADDR_LCR, LCR_ENH_KEY, "lcr_key");
        for (int a = 4; a < 8; a++) begin
            xs[a] = rnd();
            wr(3'(a), xs[a]);
        end
        for (int a = 4; a < 8; a++) begin
            rdc(3'(a), xs[a], "flow_char");
        end
        chk8("cfg_xon1", xs[4], cfg.xon1);
        chk8("cfg_xoff2", xs[7], cfg.xoff2);
        wr(ADDR_LCR, 8'h80);
        wr(ADDR_ISR, 8'hFF);
        rdc(ADDR_ISR, ~DLD_RSVD_MASK, "dld");
        chk8("cfg_dld", ~DLD_RSVD_MASK, cfg.baud_divisor_fraction);
        $display("test enhanced done");
        // enables, modem control, queue control, status: on then off
        for (int e = 1; e >= 0; e--) begin
            if (e == 0) begin
                wr(ADDR_LCR, LCR_ENH_KEY);
                wr(ADDR_ISR, 8'h00);
            end
            wr(ADDR_LCR, 8'h00);
            wr(ADDR_IER, 8'hFF);
            x = gate(8'hFF, IER_ENH_MASK, e[0]);
            rdc(ADDR_IER, x, "ier");
            wr(ADDR_MCR, 8'hFF);
            x = gate(~MCR_RSVD_MASK, MCR_ENH_MASK, e[0]);
            rdc(ADDR_MCR, x, "mcr");
            d = 8'hF6 | 8'(e);
            wr(ADDR_ISR, d);
            chk1("rx_clr", 1'b1, rx_fifo_clr);
            chk1("tx_clr", 1'b1, tx_fifo_clr);
            x = gate(d & ~FCR_PULSE_MASK, FCR_ENH_MASK, e[0]);
            chk8("cfg_fcr", x, cfg.queue_control);
            v = rnd();
            @(posedge clk);
            stat.int_source <= v[3:0];
            stat.xoff_int <= v[4];
            stat.flow_int <= v[5];
            rdc(ADDR_ISR, f_isr(v, d[0], e[0]), "isr");
        end
        $display("test gating done");
        // line state is read only
        v = rnd();
        @(posedge clk) stat.line <= v;
        wr(ADDR_LSR, ~v);
        rdc(ADDR_LSR, v, "line_state");
        // modem changes flagged, cleared by the read
        old_m = 4'h0;
        for (int i = 0; i < 4; i++) begin
            v = rnd();
            @(posedge clk) stat.modem <= v[3:0];
            repeat (2) @(posedge clk);
            rdc(ADDR_MSR, {v[3:0], v[3:0] ^ old_m}, "msr");
            rdc(ADDR_MSR, {v[3:0], 4'h0}, "msr_clr");
            old_m = v[3:0];
        end
        $display("test status done");
        end_of_test();
    end

endmodule : tb_uart_channel_register_map
